// ### core/smrc_cfg.svh
// constants for the stop mode recovery controller
//
// Summary of operation
// - delay select 0 skips power-on delay
// - delay select resets to one
// - hold execution during power-on delay
// - edge select picks high or low wake
// - edge select resets to zero
// - warm flag read-only, set on recovery
// - warm flag cleared by other resets
// - watchdog-in-stop bit, resets to one
// - timers start on clear rising edge
// - three-bit field selects wake source
`ifndef SMRC_CFG_SVH
`define SMRC_CFG_SVH
`define SMRC_OFF_SMR      12'h000
`define SMRC_OFF_WDT      12'h004
`define SMRC_OFF_STAT     12'h008
`define SMRC_OFF_MASK     12'h00C
`define SMRC_OFF_CTRL     12'h010
`define SMRC_SMR_RESET    8'h20
`define SMRC_WDT_RESET    8'h08
`define SMRC_BIT_DIV      0
`define SMRC_BIT_SRC_LO   2
`define SMRC_BIT_DLY      5
`define SMRC_BIT_EDGE     6
`define SMRC_BIT_WARM     7
`define SMRC_BIT_WDSTOP   3
`define SMRC_TPOR_NS      32'd5000000
`define SMRC_CLK_NS       32'd8
`define SMRC_TPOR_CYC     (`SMRC_TPOR_NS / `SMRC_CLK_NS)
`define SMRC_FAST_TPC     10
`define SMRC_SHORT_CYC    18
`define SMRC_SLVERR       2'b10
`define SMRC_OKAY         2'b00
`endif

// ### core/smrc_pkg.sv
// types for the stop mode recovery controller
package smrc_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_DELAY} smrc_state_t;
  typedef struct packed {
    logic       warm;
    logic       edge_high;
    logic       delay_en;
    logic [2:0] src;
    logic       rsvd;
    logic       div16;
  } smrc_smr_t;
  typedef struct packed {
    logic stop_req;
    logic clr_por;
    logic clr_short;
  } smrc_ctrl_t;
endpackage : smrc_pkg

// ### core/smrc_timer.sv
// down-counter started on the rising edge of its clear input
`timescale 1ns/10ps
`default_nettype none
module smrc_timer #(
  parameter int unsigned COUNT = 18
) (
  input  wire logic clk,     // system clock
  input  wire logic rst,     // sync reset
  input  wire logic clr,     // start on rising edge
  output logic      busy,    // timer running
  output logic      done     // one-cycle end pulse
);
  logic [31:0] cnt_r, cnt_nxt;
  logic        clr_d_r;
  logic        done_r, done_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (clr && !clr_d_r)
      cnt_nxt = COUNT;
    else if (cnt_r != 32'h0000_0000)
    begin
      cnt_nxt  = cnt_r - 32'h0000_0001;
      done_nxt = (cnt_r == 32'h0000_0001);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_r   <= 32'h0000_0000;
      clr_d_r <= 1'b0;
      done_r  <= 1'b0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      clr_d_r <= clr;
      done_r  <= done_nxt;
    end
  end

  assign busy = (cnt_r != 32'h0000_0000);
  assign done = done_r;

  chk_timer_start: assert property (@(posedge clk) disable iff (rst)
    (clr && !clr_d_r) |=> (cnt_r == COUNT))
    else $error("timer did not load on clear edge");
endmodule : smrc_timer
`default_nettype wire

// ### core/smrc_wake.sv
// wake source selection and level match
`timescale 1ns/10ps
`default_nettype none
module smrc_wake (
  input  wire logic       clk,        // system clock
  input  wire logic       rst,        // sync reset
  input  wire logic [2:0] src,        // source select
  input  wire logic       edge_high,  // wake on high level
  input  wire logic [3:0] p3,         // port 3 pins 1..3 in [2:0]
  input  wire logic [7:0] p2,         // port 2 pins
  output logic            wake        // registered wake request
);
  logic raw, lvl, wake_r, wake_nxt;

  always_comb
  begin
    unique case (src)
      3'b010:  raw = p3[0];
      3'b011:  raw = p3[1];
      3'b100:  raw = p3[2];
      3'b101:  raw = p2[7];
      3'b110:  raw = ~|p2[3:0];
      3'b111:  raw = ~|p2;
      default: raw = 1'b0;
    endcase
    lvl      = edge_high ? raw : ~raw;
    wake_nxt = lvl && (src[2] || src[1]);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      wake_r <= 1'b0;
    else
      wake_r <= wake_nxt;
  end

  assign wake = wake_r;

  chk_wake_none: assert property (@(posedge clk) disable iff (rst)
    (src[2:1] == 2'b00) |=> !wake)
    else $error("wake from reset-only source");
endmodule : smrc_wake
`default_nettype wire

// ### core/smrc_top.sv
// stop mode recovery controller with axi4-lite registers
`include "smrc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module smrc_top #(
  parameter int unsigned TPOR_CYC = `SMRC_TPOR_CYC
) (
  input  wire logic        CLK,          // 125 MHz clock
  input  wire logic        RST,          // sync reset, high
  input  wire logic        POR,          // power-on reset event
  input  wire logic [3:0]  P3_IN,        // port 3 wake pins
  input  wire logic [7:0]  P2_IN,        // port 2 wake pins
  output logic             HOLD_EXEC,    // cpu held off
  output logic             IN_STOP,      // device is stopped
  output logic             WDT_RUN,      // watchdog clock enable
  output logic             IRQ,          // interrupt level
  input  wire logic [11:0] AWADDR,       // write address
  input  wire logic        AWVALID,      // write address valid
  output logic             AWREADY,      // write address ready
  input  wire logic [31:0] WDATA,        // write data
  input  wire logic [3:0]  WSTRB,        // byte strobes
  input  wire logic        WVALID,       // write data valid
  output logic             WREADY,       // write data ready
  output logic [1:0]       BRESP,        // write response
  output logic             BVALID,       // write response valid
  input  wire logic        BREADY,       // response ready
  input  wire logic [11:0] ARADDR,       // read address
  input  wire logic        ARVALID,      // read address valid
  output logic             ARREADY,      // read address ready
  output logic [31:0]      RDATA,        // read data
  output logic [1:0]       RRESP,        // read response
  output logic             RVALID,       // read valid
  input  wire logic        RREADY        // read ready
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  smr_r, smr_nxt, wdt_r, wdt_nxt;
  logic [1:0]  stat_r, stat_nxt, mask_r, mask_nxt;
  logic        warm_r, warm_nxt, edge_r, edge_nxt;
  smrc_pkg::smrc_state_t st_r, st_nxt;
  smrc_pkg::smrc_ctrl_t  ctrl_r, ctrl_nxt;
  smrc_pkg::smrc_smr_t   smr_v;
  logic        wake, por_busy, por_done, short_busy;
  logic        aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [11:0] aw_a_r, aw_a_nxt;
  logic [31:0] w_d_r, w_d_nxt, rd_r, rd_nxt;
  logic [3:0]  w_s_r, w_s_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic        wr_go, rd_go;
  logic [1:0]  stat_clr;

  assign smr_v = smrc_pkg::smrc_smr_t'({warm_r, edge_r, smr_r[5:0]});

  ////////////////////////////////////////////////////////////////////////
  smrc_wake u_wake (
    .clk       (CLK),
    .rst       (RST),
    .src       (smr_v.src),
    .edge_high (smr_v.edge_high),
    .p3        (P3_IN),
    .p2        (P2_IN),
    .wake      (wake)
  );

  smrc_timer #(.COUNT(TPOR_CYC)) u_por (
    .clk  (CLK),
    .rst  (RST),
    .clr  (ctrl_r.clr_por),
    .busy (por_busy),
    .done (por_done)
  );

  smrc_timer #(.COUNT(`SMRC_SHORT_CYC)) u_short (
    .clk  (CLK),
    .rst  (RST),
    .clr  (ctrl_r.clr_short),
    .busy (short_busy),
    .done ()
  );

  ////////////////////////////////////////////////////////////////////////
  // stop / recovery sequencing
  always_comb
  begin
    st_nxt   = st_r;
    warm_nxt = warm_r;
    edge_nxt = edge_r;
    // clear first, so a set in the same cycle wins
    stat_nxt = stat_r & ~stat_clr;
    ctrl_nxt = ctrl_r;
    ctrl_nxt.clr_por = 1'b0;
    if (POR)
    begin
      warm_nxt = 1'b0;
      edge_nxt = 1'b0;
    end
    unique case (st_r)
      smrc_pkg::ST_RUN:
        if (ctrl_r.stop_req)
          st_nxt = smrc_pkg::ST_STOP;
      smrc_pkg::ST_STOP:
        if (wake)
        begin
          warm_nxt    = 1'b1;
          stat_nxt[0] = 1'b1;
          if (smr_v.delay_en)
          begin
            st_nxt = smrc_pkg::ST_DELAY;
            ctrl_nxt.clr_por = 1'b1;
          end
          else
            st_nxt = smrc_pkg::ST_RUN;
        end
      smrc_pkg::ST_DELAY:
        if (por_done)
        begin
          st_nxt = smrc_pkg::ST_RUN;
          stat_nxt[1] = 1'b1;
        end
    endcase
    if (st_nxt == smrc_pkg::ST_STOP)
      ctrl_nxt.stop_req = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave; one transaction each way
  assign wr_go = aw_h_r && w_h_r && !bv_r;
  assign rd_go = ARVALID && !rv_r;
  assign stat_clr = (wr_go && aw_a_r == `SMRC_OFF_STAT && w_s_r[0]) ? w_d_r[1:0] : 2'b00;

  always_comb
  begin
    aw_h_nxt = aw_h_r;
    aw_a_nxt = aw_a_r;
    w_h_nxt  = w_h_r;
    w_d_nxt  = w_d_r;
    w_s_nxt  = w_s_r;
    bv_nxt   = bv_r;
    br_nxt   = br_r;
    rv_nxt   = rv_r;
    rr_nxt   = rr_r;
    rd_nxt   = rd_r;
    smr_nxt  = smr_r;
    wdt_nxt  = wdt_r;
    mask_nxt = mask_r;
    if (AWVALID && !aw_h_r)
    begin
      aw_h_nxt = 1'b1;
      aw_a_nxt = AWADDR;
    end
    if (WVALID && !w_h_r)
    begin
      w_h_nxt = 1'b1;
      w_d_nxt = WDATA;
      w_s_nxt = WSTRB;
    end
    if (wr_go)
    begin
      aw_h_nxt = 1'b0;
      w_h_nxt  = 1'b0;
      bv_nxt   = 1'b1;
      br_nxt   = `SMRC_OKAY;
      unique case (aw_a_r)
        `SMRC_OFF_SMR:  if (w_s_r[0]) smr_nxt = {1'b0, w_d_r[6:0]};
        `SMRC_OFF_WDT:  if (w_s_r[0]) wdt_nxt = w_d_r[7:0];
        `SMRC_OFF_MASK: if (w_s_r[0]) mask_nxt = w_d_r[1:0];
        `SMRC_OFF_STAT, `SMRC_OFF_CTRL: ;
        default:        br_nxt = `SMRC_SLVERR;
      endcase
    end
    if (bv_r && BREADY)
      bv_nxt = 1'b0;
    if (rd_go)
    begin
      rv_nxt = 1'b1;
      rr_nxt = `SMRC_OKAY;
      unique case (ARADDR)
        `SMRC_OFF_SMR:  rd_nxt = {24'h00_0000, warm_r, edge_r, smr_r[5:0]};
        `SMRC_OFF_WDT:  rd_nxt = {24'h00_0000, wdt_r};
        `SMRC_OFF_STAT: rd_nxt = {30'h0000_0000, stat_r};
        `SMRC_OFF_MASK: rd_nxt = {30'h0000_0000, mask_r};
        `SMRC_OFF_CTRL: rd_nxt = {29'h0000_0000, por_busy, short_busy, IN_STOP};
        default:
        begin
          rd_nxt = 32'h0000_0000;
          rr_nxt = `SMRC_SLVERR;
        end
      endcase
    end
    else if (rv_r && RREADY)
      rv_nxt = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_r   <= smrc_pkg::ST_RUN;
      smr_r  <= `SMRC_SMR_RESET;
      wdt_r  <= `SMRC_WDT_RESET;
      warm_r <= 1'b0;
      edge_r <= 1'b0;
      stat_r <= 2'b00;
      mask_r <= 2'b00;
      ctrl_r <= '0;
      aw_h_r <= 1'b0;
      aw_a_r <= 12'h000;
      w_h_r  <= 1'b0;
      w_d_r  <= 32'h0000_0000;
      w_s_r  <= 4'h0;
      bv_r   <= 1'b0;
      br_r   <= 2'b00;
      rv_r   <= 1'b0;
      rr_r   <= 2'b00;
      rd_r   <= 32'h0000_0000;
    end
    else
    begin
      st_r   <= st_nxt;
      smr_r  <= smr_nxt;
      wdt_r  <= wdt_nxt;
      warm_r <= warm_nxt;
      mask_r <= mask_nxt;
      aw_h_r <= aw_h_nxt;
      aw_a_r <= aw_a_nxt;
      w_h_r  <= w_h_nxt;
      w_d_r  <= w_d_nxt;
      w_s_r  <= w_s_nxt;
      bv_r   <= bv_nxt;
      br_r   <= br_nxt;
      rv_r   <= rv_nxt;
      rr_r   <= rr_nxt;
      rd_r   <= rd_nxt;
      ctrl_r <= ctrl_nxt;
      // edge bit and stop/short-timer control written by software
      edge_r <= edge_nxt;
      if (wr_go && aw_a_r == `SMRC_OFF_SMR && w_s_r[0])
        edge_r <= w_d_r[`SMRC_BIT_EDGE];
      if (wr_go && aw_a_r == `SMRC_OFF_CTRL && w_s_r[0])
      begin
        ctrl_r.stop_req  <= w_d_r[0];
        ctrl_r.clr_short <= w_d_r[1];
      end
      stat_r <= stat_nxt;
    end
  end

  assign AWREADY   = !aw_h_r;
  assign WREADY    = !w_h_r;
  assign BVALID    = bv_r;
  assign BRESP     = br_r;
  assign ARREADY   = !rv_r;
  assign RVALID    = rv_r;
  assign RRESP     = rr_r;
  assign RDATA     = rd_r;
  assign IN_STOP   = (st_r == smrc_pkg::ST_STOP);
  assign HOLD_EXEC = (st_r != smrc_pkg::ST_RUN);
  assign WDT_RUN   = !IN_STOP || wdt_r[`SMRC_BIT_WDSTOP];
  assign IRQ       = |(stat_r & mask_r);

  ////////////////////////////////////////////////////////////////////////
  chk_fast_wake: assert property (@(posedge CLK) disable iff (RST)
    (IN_STOP && wake && !smr_v.delay_en) |=> (st_r == smrc_pkg::ST_RUN))
    else $error("fast wake did not resume");
  chk_slow_wake: assert property (@(posedge CLK) disable iff (RST)
    (IN_STOP && wake && smr_v.delay_en) |=> (st_r == smrc_pkg::ST_DELAY))
    else $error("delayed wake skipped delay");
  chk_hold_delay: assert property (@(posedge CLK) disable iff (RST)
    (st_r == smrc_pkg::ST_DELAY) |-> HOLD_EXEC)
    else $error("execution released during delay");
  chk_warm_set: assert property (@(posedge CLK) disable iff (RST)
    (IN_STOP && wake && !POR) |=> warm_r)
    else $error("warm flag not set on recovery");
  chk_warm_clr: assert property (@(posedge CLK) disable iff (RST)
    (POR && !IN_STOP) |=> !warm_r)
    else $error("warm flag not cleared by reset");
  chk_edge_por: assert property (@(posedge CLK) disable iff (RST)
    (POR && !(wr_go && aw_a_r == `SMRC_OFF_SMR)) |=> !edge_r)
    else $error("edge select not cleared on power-on");
  chk_wdt_stop: assert property (@(posedge CLK) disable iff (RST)
    (IN_STOP && !wdt_r[`SMRC_BIT_WDSTOP]) |-> !WDT_RUN)
    else $error("watchdog runs in stop when disabled");
  chk_reset_val: assert property (@(posedge CLK)
    (!RST && $past(RST)) |-> (smr_r[`SMRC_BIT_DLY] && wdt_r[`SMRC_BIT_WDSTOP]))
    else $error("reset values wrong");
  cov_fast: cover property (@(posedge CLK) IN_STOP && wake && !smr_v.delay_en);
  cov_slow: cover property (@(posedge CLK) por_done && st_r == smrc_pkg::ST_DELAY);
  cov_irq:  cover property (@(posedge CLK) IRQ);
endmodule : smrc_top
`default_nettype wire

// ### verif/smrc_pins.sv
// wake-source pins on ports 2 and 3, driven on command from the bench
`include "smrc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module smrc_pins (
  input  wire logic       clk,  // system clock
  output logic      [3:0] p3,   // port 3 pins
  output logic      [7:0] p2    // port 2 pins
);
  logic wake_lvl_r;
  initial
  begin
    wake_lvl_r = 1'b0;
    p3 = 4'hF;
    p2 = 8'hFF;
  end
  ////////////////////////////////////////////////////////////////////////
  // park every pin at the inactive level, else stop is left at once
  task automatic idle(input logic high);
    @(posedge clk);
    wake_lvl_r <= high;
    p3 <= {4{~high}};
    p2 <= {8{~high}};
  endtask : idle
  // index 0..2 is port 3 pin 1..3, index 3 is port 2 pin 7
  task automatic pulse(input int idx, input int hold);
    int n;
    n = (hold < `SMRC_FAST_TPC) ? `SMRC_FAST_TPC : hold;
    @(posedge clk);
    if (idx < 3) p3[idx] <= wake_lvl_r;
    else p2[7] <= wake_lvl_r;
    repeat (n) @(posedge clk);
    if (idx < 3) p3[idx] <= ~wake_lvl_r;
    else p2[7] <= ~wake_lvl_r;
  endtask : pulse
endmodule : smrc_pins
`default_nettype wire

// ### verif/stop_mode_recovery_control_test.sv
// self-checking bench for the stop mode recovery controller
`include "smrc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH t=%0t %s", $time, m); end end
module stop_mode_recovery_control_test;
  localparam int TPOR = 20;
  logic        CLK, RST, POR, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0]  WSTRB, P3_IN;
  logic [7:0]  P2_IN;
  logic        HOLD_EXEC, IN_STOP, WDT_RUN, IRQ, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0]  BRESP, RRESP, r;
  logic        edge_hi, dly, wd;
  int          miscompares, check_count, cyc, n;
  smrc_top #(.TPOR_CYC(TPOR)) dut_u (.CLK(CLK), .RST(RST), .POR(POR), .P3_IN(P3_IN), .P2_IN(P2_IN),
    .HOLD_EXEC(HOLD_EXEC), .IN_STOP(IN_STOP), .WDT_RUN(WDT_RUN), .IRQ(IRQ), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY));
  smrc_pins pins_u (.clk(CLK), .p3(P3_IN), .p2(P2_IN));
  ////////////////////////////////////////////////////////////////////////
  initial CLK = 1'b0;
  always #4 CLK = ~CLK;
  // whole run is a few hundred cycles; this only catches a hang
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= v;
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do
    begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end
    while (!(BVALID && BREADY));
    resp = BRESP;
    BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do
    begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end
    while (!(RVALID && RREADY));
    v = RDATA;
    resp = RRESP;
    RREADY <= 1'b0;
  endtask : rd
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {RST, POR} = 2'b11;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    {miscompares, check_count, cyc} = '0;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    POR <= 1'b0;
    rd(`SMRC_OFF_SMR, d, r);
    `CHK(d[7:0], 8'h20, "smr reset")
    rd(`SMRC_OFF_WDT, d, r);
    `CHK(d[7:0], 8'h08, "wdt reset")
    wr(`SMRC_OFF_STAT, 32'h0000_00FF, r);
    wr(`SMRC_OFF_MASK, 32'h0000_0000, r);
    for (int i = 0; i < 4; i++)
    begin
      edge_hi = i[0];
      dly = i[1]; // fast wake only models an rc clock
      wd = i[0] ^ i[1];
      pins_u.idle(edge_hi);
      wr(`SMRC_OFF_SMR, {24'h0000_00, 1'b0, edge_hi, dly, 3'(i + 2), 2'b00}, r);
      wr(`SMRC_OFF_WDT, {28'h000_0000, wd, 3'b000}, r);
      wr(`SMRC_OFF_CTRL, 32'h0000_0001, r);
      wr(`SMRC_OFF_CTRL, 32'h0000_0000, r);
      #1;
      `CHK(IN_STOP, 1'b1, "not stopped")
      `CHK(WDT_RUN, wd, "watchdog run in stop")
      // a source that is not selected must leave the device stopped
      pins_u.pulse((i + 1) % 4, 10);
      #1;
      `CHK(HOLD_EXEC, 1'b1, "woke on other pin")
      n = 0;
      fork
        pins_u.pulse(i, 10);
        do
        begin
          @(posedge CLK);
          #1;
          n++;
        end
        while (HOLD_EXEC !== 1'b0 && n < 200);
      join
      if (dly)
        `CHK((n > TPOR) && (n <= TPOR + 8), 1'b1, "delayed resume")
      else
        `CHK(n <= 4, 1'b1, "fast resume")
      `CHK(IN_STOP, 1'b0, "still stopped")
      rd(`SMRC_OFF_SMR, d, r);
      `CHK(d[7], 1'b1, "warm flag")
    end
    // wake and delay-done both pending, masked off
    rd(`SMRC_OFF_STAT, d, r);
    `CHK(d[1:0], 2'b11, "status")
    `CHK(IRQ, 1'b0, "masked irq")
    wr(`SMRC_OFF_MASK, 32'h0000_0001, r);
    repeat (2) @(posedge CLK);
    #1;
    `CHK(IRQ, 1'b1, "unmasked irq")
    wr(`SMRC_OFF_STAT, 32'h0000_0001, r);
    repeat (2) @(posedge CLK);
    #1;
    `CHK(IRQ, 1'b0, "irq after clear")
    rd(`SMRC_OFF_STAT, d, r);
    `CHK(d[1:0], 2'b10, "w1c status")
    // a power-on event is a cold start
    wr(`SMRC_OFF_SMR, 32'h0000_0060, r);
    @(posedge CLK);
    POR <= 1'b1;
    @(posedge CLK);
    POR <= 1'b0;
    rd(`SMRC_OFF_SMR, d, r);
    `CHK(d[7:6], 2'b00, "cold start")
    wr(`SMRC_OFF_CTRL, 32'h0000_0002, r);
    rd(`SMRC_OFF_CTRL, d, r);
    `CHK(d[1], 1'b1, "short timer start")
    repeat (24) @(posedge CLK);
    rd(`SMRC_OFF_CTRL, d, r);
    `CHK(d[1], 1'b0, "short timer end")
    wr(`SMRC_OFF_CTRL, 32'h0000_0000, r);
    wr(12'h100, 32'h0000_0001, r);
    `CHK(r, `SMRC_SLVERR, "unmapped write")
    rd(12'h100, d, r);
    `CHK(r, `SMRC_SLVERR, "unmapped read")
    `CHK(d, 32'h0000_0000, "unmapped data")
    wrap_up();
  end
endmodule : stop_mode_recovery_control_test
`default_nettype wire
